// ===== verilog/charge_sequencer.sv
`timescale 1ns/1ps
// Behaviour
// RL1 - Charge mode or high-impedance mode, both blocked
// RL2 - Linear precharge below short threshold, then switching
// RL3 - Charge current ramps with limited slew
// RL4 - Thermal limit keeps reducing charge current
// RL5 - Input floor droop reduces charge current
// RL6 - Float voltage 3.50 V plus 20 mV, capped
// RL7 - Current, termination and weak-battery field positions
// RL8 - Termination enable bit gates current termination
// RL9 - Low current at float voltage completes cycle
// RL10 - Recharge below float minus hysteresis
// RL11 - Power-on clear with weak battery restarts
// RL12 - Charge-enable or reset bit restarts cycle
// RL13 - Ready for 500 ms, then done
// RL14 - Weak-battery power-on restores defaults, enables charge
// RL15 - Fields take effect after complete write
module charge_sequencer
  import charger_pkg::*;
#(
  parameter int DONE_CYCLES = DONE_CHECK_CYCLES
) (
  input  wire logic              sys_clk,       // 200 MHz core clock
  input  wire logic              rst_n,         // Async reset, active low
  input  wire logic [ADDR_W-1:0] reg_addr,      // Register address
  input  wire logic [DATA_W-1:0] reg_wdata,     // Write data
  input  wire logic              reg_wr,        // Write strobe
  input  wire logic              reg_rd,        // Read strobe
  output logic      [DATA_W-1:0] reg_rdata,     // Read data, cycle after strobe
  input  wire sense_t            sense_raw,     // Analog comparator pins
  output logic                   high_impedance,// Paths blocked both ways
  output logic                   precharge_en,  // Linear source on
  output logic                   pwm_en,        // Switching charger on
  output logic      [2:0]        charge_current,// Ramped current command
  output logic      [12:0]       float_mv,      // Float voltage, mV
  output logic      [2:0]        term_code,     // Termination current code
  output logic      [1:0]        weak_code,     // Weak-battery threshold code
  output logic      [1:0]        status_code,   // Charge status
  output logic                   irq            // Level interrupt
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // 4.44 V needs 13 bits; a 12-bit result would wrap above 4.095 V
  function automatic logic [12:0] float_decode(input logic [5:0] code);
    logic [5:0] c;
    c = (code > FLOAT_MAX_CODE) ? FLOAT_MAX_CODE : code;
    return 13'(FLOAT_BASE_MV + 13'(c) * FLOAT_STEP_MV);
  endfunction

  function automatic cfg_t cfg_from(input logic [7:0] one, input logic [7:0] two,
                                    input logic [7:0] four);
    cfg_t c;
    c.float_voltage_code       = two[FLOAT_LSB +: 6];
    c.charge_current_code      = four[CHG_LSB +: 3];
    c.termination_current_code = four[TERM_LSB +: 3];
    c.weak_battery_threshold   = one[WEAK_LSB +: 2];
    c.termination_enable       = one[TE_BIT];
    return c;
  endfunction

  // ------------------------------------------------------------
  // Synchronised sense inputs
  // ------------------------------------------------------------
  sense_t sense;
  sense_t sense_q;

  sense_sync u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .raw     (sense_raw),
    .synced  (sense)
  );

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [7:0]       ctrl_one;
  logic [7:0]       volt_two;
  logic [7:0]       cur_four;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [7:0]       next_ctrl_one;
  logic [7:0]       next_volt_two;
  logic [7:0]       next_cur_four;
  logic [IRQ_W-1:0] next_irq_stat;
  logic [IRQ_W-1:0] next_irq_mask;
  logic [7:0]       next_rdata;
  logic             next_irq;
  cfg_t             cfg;
  cfg_t             next_cfg;
  logic             commit;
  logic             next_commit;
  logic             restart_req;
  logic             next_restart_req;
  logic             por_restart;
  logic [IRQ_W-1:0] events;

  // Weak-battery power-on: POR clears while below the weak threshold
  assign por_restart = sense.vin_por_ok && !sense_q.vin_por_ok && sense.below_weak; // RL11 RL14

  always_comb begin
    next_ctrl_one    = ctrl_one;
    next_volt_two    = volt_two;
    next_cur_four    = cur_four;
    next_irq_mask    = irq_mask;
    next_commit      = 1'b0;
    next_restart_req = 1'b0;
    next_rdata       = 8'h00;
    // Reset bit self-clears so it reads back zero
    next_ctrl_one[RESET_BIT] = 1'b0;
    if (reg_wr) begin
      next_commit = 1'b1;
      unique case (reg_addr)
        CTRL_ONE_OFS: begin
          next_ctrl_one    = reg_wdata;
          next_restart_req = reg_wdata[CE_BIT] | reg_wdata[RESET_BIT]; // RL12
        end
        VOLT_TWO_OFS: next_volt_two = reg_wdata;
        CUR_FOUR_OFS: next_cur_four = reg_wdata;
        IRQ_MASK_OFS: next_irq_mask = reg_wdata[IRQ_W-1:0];
        default:      next_commit   = 1'b0;
      endcase
    end
    if (reg_wr && reg_addr == CTRL_ONE_OFS && reg_wdata[RESET_BIT]) begin
      next_ctrl_one = CTRL_ONE_RST;
      next_volt_two = VOLT_TWO_RST;
      next_cur_four = CUR_FOUR_RST;
    end
    if (por_restart) begin
      next_ctrl_one = CTRL_ONE_RST; // RL14
      next_volt_two = VOLT_TWO_RST;
      next_cur_four = CUR_FOUR_RST;
      next_commit   = 1'b1;
    end
    // Set beats write-one-to-clear
    next_irq_stat = irq_stat;
    if (reg_wr && reg_addr == IRQ_STAT_OFS)
      next_irq_stat = irq_stat & ~reg_wdata[IRQ_W-1:0];
    next_irq_stat = next_irq_stat | events;
    next_irq      = |(next_irq_stat & next_irq_mask);
    if (reg_rd) begin
      unique case (reg_addr)
        STATUS_OFS:   next_rdata = {2'b00, status_code, 4'h0};
        CTRL_ONE_OFS: next_rdata = ctrl_one;
        VOLT_TWO_OFS: next_rdata = volt_two;
        CUR_FOUR_OFS: next_rdata = {1'b0, cur_four[6:0]}; // RL7
        IRQ_STAT_OFS: next_rdata = 8'(irq_stat);
        IRQ_MASK_OFS: next_rdata = 8'(irq_mask);
        default:      next_rdata = 8'h00;
      endcase
    end
    // Charge logic sees the new fields only once the write has landed
    next_cfg = commit ? cfg_from(ctrl_one, volt_two, cur_four) : cfg; // RL15 RL7
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_one    <= CTRL_ONE_RST;
      volt_two    <= VOLT_TWO_RST;
      cur_four    <= CUR_FOUR_RST;
      irq_stat    <= '0;
      irq_mask    <= IRQ_W'(IRQ_MASK_RST);
      reg_rdata   <= 8'h00;
      irq         <= 1'b0;
      commit      <= 1'b0;
      restart_req <= 1'b0;
      cfg         <= cfg_from(CTRL_ONE_RST, VOLT_TWO_RST, CUR_FOUR_RST);
      sense_q     <= '0;
    end else begin
      ctrl_one    <= next_ctrl_one;
      volt_two    <= next_volt_two;
      cur_four    <= next_cur_four;
      irq_stat    <= next_irq_stat;
      irq_mask    <= next_irq_mask;
      reg_rdata   <= next_rdata;
      irq         <= next_irq;
      commit      <= next_commit;
      restart_req <= next_restart_req;
      cfg         <= next_cfg;
      sense_q     <= sense;
    end
  end

  // ------------------------------------------------------------
  // Charge sequencer
  // ------------------------------------------------------------
  state_t      state;
  state_t      next_state;
  logic [26:0] wait_cnt;
  logic [26:0] next_wait_cnt;
  logic        next_high_impedance;
  logic        next_precharge_en;
  logic        next_pwm_en;
  logic [1:0]  next_status_code;
  logic [12:0] next_float_mv;
  logic [2:0]  next_term_code;
  logic [1:0]  next_weak_code;
  logic        charge_allowed;
  logic        new_cycle;
  logic        pwm_run;

  assign charge_allowed = ctrl_one[CE_BIT] && !ctrl_one[HZ_BIT] && sense.vin_por_ok;
  // Restart request takes a cycle so ctrl_one holds the write first; cfg lands on the same edge as the restart
  assign new_cycle      = restart_req || por_restart; // RL11 RL12

  always_comb begin
    next_state    = state;
    next_wait_cnt = wait_cnt;
    events        = '0;
    unique case (state)
      ST_HIZ: begin
        if (charge_allowed) begin
          next_state       = ST_PRECHARGE;
          events[IRQ_CYCLE] = 1'b1;
        end
      end
      ST_PRECHARGE: begin
        if (!sense.below_short)
          next_state = ST_FAST; // RL2
      end
      ST_FAST: begin
        if (sense.below_short)
          next_state = ST_PRECHARGE; // RL2
        else if (sense.cv_active && sense.below_term && cfg.termination_enable) begin // RL8 RL9
          next_state     = ST_DONE_CHECK;
          next_wait_cnt  = '0;
          events[IRQ_TERM] = 1'b1;
        end
      end
      ST_DONE_CHECK: begin
        next_wait_cnt = wait_cnt + 27'h1;
        if (wait_cnt == 27'(DONE_CYCLES - 1)) begin // RL13
          if (sense.battery_present && sense.vin_por_ok) begin
            next_state       = ST_DONE;
            events[IRQ_DONE] = 1'b1;
          end else begin
            next_state        = ST_HIZ;
            events[IRQ_FAULT] = 1'b1;
          end
        end
      end
      ST_DONE: begin
        if (sense.below_recharge) begin
          next_state        = ST_PRECHARGE; // RL10
          events[IRQ_CYCLE] = 1'b1;
        end
      end
      default: next_state = ST_HIZ;
    endcase
    if (new_cycle && charge_allowed && state != ST_HIZ) begin
      next_state        = ST_PRECHARGE; // RL12
      events[IRQ_CYCLE] = 1'b1;
    end
    if (!charge_allowed) begin
      if (state != ST_HIZ && !sense.vin_por_ok)
        events[IRQ_FAULT] = 1'b1;
      next_state = ST_HIZ; // RL1
    end
    next_high_impedance = (next_state == ST_HIZ); // RL1
    next_precharge_en   = (next_state == ST_PRECHARGE); // RL2
    next_pwm_en         = (next_state == ST_FAST);
    unique case (next_state)
      ST_PRECHARGE, ST_FAST: next_status_code = STAT_CHARGING;
      ST_DONE:               next_status_code = STAT_DONE; // RL13
      ST_HIZ:                next_status_code = sense.vin_por_ok ? STAT_READY : STAT_FAULT;
      default:               next_status_code = STAT_READY; // RL13
    endcase
    next_float_mv  = float_decode(cfg.float_voltage_code); // RL6
    next_term_code = cfg.termination_current_code;
    next_weak_code = cfg.weak_battery_threshold;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state          <= ST_HIZ;
      wait_cnt       <= '0;
      high_impedance <= 1'b1;
      precharge_en   <= 1'b0;
      pwm_en         <= 1'b0;
      status_code    <= STAT_READY;
      float_mv       <= FLOAT_BASE_MV;
      term_code      <= 3'h0;
      weak_code      <= 2'h0;
    end else begin
      state          <= next_state;
      wait_cnt       <= next_wait_cnt;
      high_impedance <= next_high_impedance;
      precharge_en   <= next_precharge_en;
      pwm_en         <= next_pwm_en;
      status_code    <= next_status_code;
      float_mv       <= next_float_mv;
      term_code      <= next_term_code;
      weak_code      <= next_weak_code;
    end
  end

  // ------------------------------------------------------------
  // Slew-limited current command
  // ------------------------------------------------------------
  assign pwm_run = (state == ST_FAST);

  current_ramp u_ramp (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .enable  (pwm_run),
    .target  (cfg.charge_current_code),
    .reduce  (sense.temp_limit | sense.vin_floor), // RL4 RL5
    .level   (charge_current)
  );

endmodule // charge_sequencer

// ===== verilog/charger_pkg.sv
package charger_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int         ADDR_W        = 3;
  localparam int         DATA_W        = 8;
  localparam logic [2:0] STATUS_OFS    = 3'h0;
  localparam logic [2:0] CTRL_ONE_OFS  = 3'h1;
  localparam logic [2:0] VOLT_TWO_OFS  = 3'h2;
  localparam logic [2:0] CUR_FOUR_OFS  = 3'h4;
  localparam logic [2:0] IRQ_STAT_OFS  = 3'h6;
  localparam logic [2:0] IRQ_MASK_OFS  = 3'h7;

  // Field positions
  localparam int RESET_BIT     = 7;
  localparam int WEAK_LSB      = 4;
  localparam int TE_BIT        = 3;
  localparam int CE_BIT        = 2;
  localparam int HZ_BIT        = 1;
  localparam int FLOAT_LSB     = 2;
  localparam int CHG_LSB       = 4;
  localparam int TERM_LSB      = 0;
  localparam int STAT_LSB      = 4;

  // Reset values
  localparam logic [7:0] CTRL_ONE_RST  = 8'h14;
  localparam logic [7:0] VOLT_TWO_RST  = 8'h08;
  localparam logic [7:0] CUR_FOUR_RST  = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST  = 8'h00;

  // Float voltage decode, millivolts
  localparam logic [12:0] FLOAT_BASE_MV  = 13'h0dac;
  localparam logic [12:0] FLOAT_STEP_MV  = 13'h0014;
  localparam logic [5:0]  FLOAT_MAX_CODE = 6'h2f;

  // Status codes
  localparam logic [1:0] STAT_READY    = 2'h0;
  localparam logic [1:0] STAT_CHARGING = 2'h1;
  localparam logic [1:0] STAT_DONE     = 2'h2;
  localparam logic [1:0] STAT_FAULT    = 2'h3;

  // Interrupt status bits
  localparam int IRQ_W     = 4;
  localparam int IRQ_CYCLE = 0;
  localparam int IRQ_TERM  = 1;
  localparam int IRQ_DONE  = 2;
  localparam int IRQ_FAULT = 3;

  // Timing
  localparam int CLK_MHZ           = 200;
  localparam int DONE_CHECK_MS     = 500;
  localparam int DONE_CHECK_CYCLES = DONE_CHECK_MS * CLK_MHZ * 1000;
  localparam int RAMP_STEP_NS      = 1000;
  localparam int RAMP_STEP_CYCLES  = RAMP_STEP_NS * CLK_MHZ / 1000;

  typedef struct packed {
    logic [5:0] float_voltage_code;
    logic [2:0] charge_current_code;
    logic [2:0] termination_current_code;
    logic [1:0] weak_battery_threshold;
    logic       termination_enable;
  } cfg_t;

  typedef struct packed {
    logic below_short;
    logic below_recharge;
    logic below_weak;
    logic below_term;
    logic cv_active;
    logic temp_limit;
    logic vin_floor;
    logic vin_por_ok;
    logic battery_present;
  } sense_t;

  typedef enum logic [4:0] {
    ST_HIZ        = 5'b00001,
    ST_PRECHARGE  = 5'b00010,
    ST_FAST       = 5'b00100,
    ST_DONE_CHECK = 5'b01000,
    ST_DONE       = 5'b10000
  } state_t;

endpackage

// ===== verilog/sense_sync.sv
`timescale 1ns/1ps
module sense_sync
  import charger_pkg::*;
(
  input  wire logic   sys_clk,  // Core clock
  input  wire logic   rst_n,    // Async reset, active low
  input  wire sense_t raw,      // Comparator pins
  output sense_t      synced    // Two-stage synchronised copy
);

  sense_t meta;
  sense_t next_meta;
  sense_t next_synced;

  always_comb begin
    next_meta   = raw;
    next_synced = meta;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta   <= '0;
      synced <= '0;
    end else begin
      meta   <= next_meta;
      synced <= next_synced;
    end
  end

endmodule // sense_sync

// ===== verilog/current_ramp.sv
`timescale 1ns/1ps
module current_ramp
  import charger_pkg::*;
(
  input  wire logic       sys_clk,  // Core clock
  input  wire logic       rst_n,    // Async reset, active low
  input  wire logic       enable,   // Switching charger running
  input  wire logic [2:0] target,   // Programmed current code
  input  wire logic       reduce,   // Thermal or input floor limiting
  output logic      [2:0] level     // Current command
);

  logic [7:0] tick_cnt;
  logic [7:0] next_tick_cnt;
  logic [2:0] next_level;
  logic       tick;

  // ------------------------------------------------------------
  // One step per tick so the loop never overshoots the target
  // ------------------------------------------------------------
  always_comb begin
    tick          = (tick_cnt == 8'(RAMP_STEP_CYCLES - 1));
    next_tick_cnt = tick ? 8'h00 : tick_cnt + 8'h01;
    next_level    = level;
    if (!enable) begin
      next_level    = 3'h0;
      next_tick_cnt = 8'h00;
    end else if (tick) begin
      if (reduce && level != 3'h0)
        next_level = level - 3'h1; // RL4 RL5
      else if (!reduce && level < target)
        next_level = level + 3'h1; // RL3
      else if (level > target)
        next_level = level - 3'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 8'h00;
      level    <= 3'h0;
    end else begin
      tick_cnt <= next_tick_cnt;
      level    <= next_level;
    end
  end

endmodule // current_ramp

// ===== test/charger_properties.sv
`timescale 1ns/1ps
module charger_properties
  import charger_pkg::*;
(
  input wire logic              sys_clk,        // Core clock
  input wire logic              rst_n,          // Reset, active low
  input wire logic              reg_rd,         // Read strobe
  input wire logic [DATA_W-1:0] reg_rdata,      // Read data
  input wire logic              high_impedance, // Blocked mode
  input wire logic              precharge_en,   // Linear source on
  input wire logic              pwm_en,         // Switching on
  input wire logic [2:0]        charge_current, // Current command
  input wire logic [12:0]       float_mv,       // Float voltage
  input wire logic [1:0]        status_code     // Charge status
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_hiz_blocks: assert property (high_impedance |-> !pwm_en && !precharge_en)
    else $error("charge path on in high impedance");
  a_one_source: assert property (!(pwm_en && precharge_en))
    else $error("linear and switching both on");
  a_pwm_after_pre: assert property ($rose(pwm_en) |-> $past(precharge_en))
    else $error("switching started without precharge phase");
  a_ramp_slew: assert property (pwm_en && $past(pwm_en) && $changed(charge_current) |->
    charge_current == $past(charge_current) + 3'h1 || charge_current == $past(charge_current) - 3'h1)
    else $error("charge current jumped");
  a_float_range: assert property (float_mv >= FLOAT_BASE_MV && float_mv <= 13'h1158)
    else $error("float voltage out of range");
  a_float_step: assert property ((float_mv - FLOAT_BASE_MV) % FLOAT_STEP_MV == 13'h0000)
    else $error("float voltage off step");
  a_pwm_status: assert property (pwm_en |-> status_code == STAT_CHARGING)
    else $error("status not charging while switching");
  a_done_ready: assert property ($rose(status_code == STAT_DONE) |->
    $past(status_code) == STAT_READY && !pwm_en)
    else $error("done not preceded by ready");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  c_done: cover property ($rose(status_code == STAT_DONE));
endmodule // charger_properties

bind charge_sequencer charger_properties u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .high_impedance(high_impedance), .precharge_en(precharge_en), .pwm_en(pwm_en),
  .charge_current(charge_current), .float_mv(float_mv), .status_code(status_code)
);

// ===== test/cell_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Battery and source comparators seen by the charger
// ----------------------------------------------------------------
module cell_model
  import charger_pkg::*;
#(
  parameter int SHORT_MV     = 2000,
  parameter int RCH_MV       = 120,  // Hysteresis, plain default
  parameter int WEAK_MV      = 3400, // Weak threshold base, plain default
  parameter int WEAK_STEP_MV = 100
) (
  input  wire logic [12:0] vbat_mv,   // Cell voltage
  input  wire logic [12:0] float_mv,  // Charger float target
  input  wire logic [1:0]  weak_code, // Active weak code
  input  wire logic        term_low,  // Current under termination level
  input  wire logic        hot,       // Die at regulation point
  input  wire logic        droop,     // Input at its floor
  input  wire logic        vin_ok,    // Input power-on cleared
  input  wire logic        present,   // Cell attached
  output sense_t           sense_raw  // Comparator pins
);
  always_comb begin
    sense_raw.below_short     = int'(vbat_mv) < SHORT_MV;
    sense_raw.below_recharge  = int'(vbat_mv) < int'(float_mv) - RCH_MV;
    sense_raw.below_weak      = int'(vbat_mv) < WEAK_MV + WEAK_STEP_MV * int'(weak_code);
    sense_raw.below_term      = term_low;
    sense_raw.cv_active       = int'(vbat_mv) >= int'(float_mv);
    sense_raw.temp_limit      = hot;
    sense_raw.vin_floor       = droop;
    sense_raw.vin_por_ok      = vin_ok;
    sense_raw.battery_present = present;
  end
endmodule // cell_model

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import charger_pkg::*;
  localparam int DONE_N = 50;
  logic        sys_clk, rst_n, reg_wr, reg_rd, irq, high_impedance, precharge_en, pwm_en;
  logic [2:0]  reg_addr, charge_current, term_code;
  logic [7:0]  reg_wdata, reg_rdata, rdv;
  logic [12:0] float_mv;
  logic [1:0]  weak_code, status_code;
  logic [12:0] vbat_mv;
  logic        term_low, hot, droop, vin_ok, present;
  logic [5:0]  code;
  logic [5:0]  edge_codes [5] = '{6'h00, 6'h2e, 6'h2f, 6'h30, 6'h3f};
  sense_t      sense_raw;
  int          bad_count, checks_done, seed, n, k;
  int          shadow [8];

  charge_sequencer #(.DONE_CYCLES(DONE_N)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sense_raw(sense_raw), .high_impedance(high_impedance),
    .precharge_en(precharge_en), .pwm_en(pwm_en), .charge_current(charge_current), .float_mv(float_mv),
    .term_code(term_code), .weak_code(weak_code), .status_code(status_code), .irq(irq));
  cell_model u_cell (.vbat_mv(vbat_mv), .float_mv(float_mv), .weak_code(weak_code), .term_low(term_low),
    .hot(hot), .droop(droop), .vin_ok(vin_ok), .present(present), .sense_raw(sense_raw));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    if (a == CTRL_ONE_OFS || a == VOLT_TWO_OFS || a == CUR_FOUR_OFS) shadow[a] = int'(d);
    if (a == IRQ_MASK_OFS) shadow[a] = int'(d & 8'h0f);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rd_chk(input logic [2:0] a);
    logic [7:0] v;
    rd(a, v);
    chk(v === 8'(shadow[a]), "register read back");
  endtask
  task automatic wait_stat(input logic [1:0] s, output int c);
    c = 0;
    while (status_code !== s && c < 400) begin
      cyc(1);
      c++;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Far above the few thousand cycles the sequence needs
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    stop_test();
  end

  initial begin
    seed = 32'h51a4;
    shadow = '{default: 0};
    shadow[1] = 8'h14;
    shadow[2] = 8'h08;
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {term_low, hot, droop, vin_ok} = '0;
    present = 1'b1;
    vbat_mv = 13'h05dc;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    cyc(2);
    chk(high_impedance === 1'b1 && float_mv === 13'h0dd4, "reset outputs");
    wr(3'h3, 8'h5a);
    wr(3'h5, 8'ha5);
    for (int a = 1; a < 8; a++) if (a != 6) rd_chk(3'(a));
    for (n = 0; n < 12; n++) begin
      code = (n < 5) ? edge_codes[n] : 6'($random(seed));
      wr(VOLT_TWO_OFS, {code, 2'($random(seed))});
      cyc(4);
      chk(float_mv === FLOAT_BASE_MV + FLOAT_STEP_MV * 13'((code > FLOAT_MAX_CODE) ? FLOAT_MAX_CODE : code), "float");
    end
    for (n = 0; n < 4; n++) begin
      wr(CUR_FOUR_OFS, {1'b0, 3'($random(seed)), 1'b0, 3'($random(seed))});
      wr(CTRL_ONE_OFS, {2'b00, 2'($random(seed)), 4'h4});
      cyc(4);
      chk(term_code === 3'(shadow[4]) && weak_code === 2'(shadow[1] >> 4), "field decode");
    end
    // Power-on with a weak cell must throw the programmed fields away
    wr(CTRL_ONE_OFS, 8'h14);
    wr(CUR_FOUR_OFS, 8'h35);
    @(posedge sys_clk) vin_ok <= 1'b1;
    cyc(8);
    shadow = '{default: 0};
    shadow[1] = 8'h14;
    shadow[2] = 8'h08;
    rd_chk(CUR_FOUR_OFS);
    rd_chk(VOLT_TWO_OFS);
    chk(precharge_en === 1'b1 && pwm_en === 1'b0 && status_code === STAT_CHARGING, "precharge");
    rd(IRQ_STAT_OFS, rdv);
    chk(rdv[IRQ_CYCLE] === 1'b1 && irq === 1'b0, "masked cycle event");
    wr(CUR_FOUR_OFS, 8'h30);
    @(posedge sys_clk) vbat_mv <= 13'h0bb8;
    cyc(8);
    chk(pwm_en === 1'b1 && precharge_en === 1'b0, "switching after short");
    cyc(1000);
    chk(charge_current === 3'h3, "ramp target");
    @(posedge sys_clk) hot <= 1'b1;
    cyc(450);
    chk(charge_current < 3'h3, "thermal reduce");
    @(posedge sys_clk) hot <= 1'b0;
    cyc(1000);
    @(posedge sys_clk) droop <= 1'b1;
    cyc(450);
    chk(charge_current < 3'h3, "input floor reduce");
    @(posedge sys_clk) droop <= 1'b0;
    @(posedge sys_clk) {vbat_mv, term_low} <= {13'h0e10, 1'b1};
    cyc(300);
    chk(pwm_en === 1'b1 && status_code === STAT_CHARGING, "no termination");
    wr(IRQ_MASK_OFS, 8'h04);
    wr(CTRL_ONE_OFS, 8'h1c);
    wait_stat(STAT_READY, k);
    chk(pwm_en === 1'b0 && status_code === STAT_READY, "ready after termination");
    wait_stat(STAT_DONE, k);
    cyc(3);
    chk(k >= DONE_N - 2 && k <= DONE_N + 4 && irq === 1'b1, "done delay and irq");
    wr(IRQ_STAT_OFS, 8'h04);
    cyc(3);
    chk(irq === 1'b0, "irq cleared");
    @(posedge sys_clk) {vbat_mv, term_low} <= {13'h0ce4, 1'b0};
    cyc(20);
    chk(status_code === STAT_CHARGING, "recharge");
    wr(CTRL_ONE_OFS, 8'h1e);
    cyc(8);
    chk(high_impedance === 1'b1 && pwm_en === 1'b0 && precharge_en === 1'b0, "hiz mode");
    wr(CTRL_ONE_OFS, 8'h1c);
    cyc(8);
    chk(pwm_en === 1'b1 && high_impedance === 1'b0, "restart by enable");
    @(posedge sys_clk) vin_ok <= 1'b0;
    cyc(8);
    chk(high_impedance === 1'b1 && status_code === STAT_FAULT, "input lost");
    stop_test();
  end
endmodule // testbench
